/* File: hdl/csrr_status_regs.sv */
`timescale 1ns/1ps
module csrr_status_regs
    import csrr_pkg::*;
(
    input wire logic clk, // System clock, 125 MHz
    input wire logic sys_rst, // Synchronous reset, active high
    // Register access port
    input wire logic rdReq, // Read request pulse
    input wire logic [3:0] rdAddr, // Read offset
    input wire logic wrReq, // Write request pulse
    input wire logic [3:0] wrAddr, // Write offset
    output logic [15:0] rdData, // Read data, valid with rdValid
    output logic rdValid, // Read answer pulse
    output logic wrRefused, // Write ignored pulse
    // Conversion engine side
    input wire logic convStart, // New conversion set begins
    input wire logic convDone, // Conversion set complete
    input wire logic [FRESH_W-1:0] convFresh, // {angle, temp, z, y, x} in this set
    input wire logic [15:0] xResult, // X field result
    input wire logic [15:0] yResult, // Y field result
    input wire logic [15:0] zResult, // Z field result
    input wire logic [15:0] tempResult, // Temperature result
    // Diagnostic events
    input wire logic sensorDiagFail, // Front-end sensor diagnostic failed
    input wire logic tempDiagFail, // Temperature diagnostic failed
    input wire logic zElementDiagFail, // Z element diagnostic failed
    input wire logic yElementDiagFail, // Y element diagnostic failed
    input wire logic xElementDiagFail, // X element diagnostic failed
    input wire logic trimDataError, // Trim data error
    input wire logic internalSupplyFault, // Internal supply fault
    // System events
    input wire logic frameError, // Wrong clock count in a frame
    input wire logic crcError, // Checksum error
    input wire logic [3:0] thresholdCross, // {temp, z, y, x} crossings
    // Status outputs
    output logic convReady, // Conversion set ready
    output logic [1:0] alertSummary // Alert source summary
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // True when the offset falls in the result window
    function automatic logic isResult(input logic [3:0] addr);
        isResult = (addr >= OFF_X_RESULT) && (addr <= OFF_THERMAL);
    endfunction

    // Offset to result bank index
    function automatic logic [1:0] resultIdx(input logic [3:0] addr);
        logic [3:0] diff;
        diff = addr - OFF_X_RESULT;
        resultIdx = diff[1:0];
    endfunction

    // True when an offset names one of this block's words
    function automatic logic isMapped(input logic [3:0] addr);
        isMapped = (addr >= OFF_CONV_STATE) && (addr <= OFF_SYS_FLAGS);
    endfunction

    // Front-end bank bits placed into the 16-bit word; others read zero
    function automatic logic [15:0] feWord(input logic [FE_FLAGS-1:0] b);
        logic [15:0] w;
        w = 16'h0000;
        w[FE_POWER_UP] = b[7];
        w[FE_SENSOR] = b[6];
        w[FE_TEMP] = b[5];
        w[FE_Z] = b[4];
        w[FE_Y] = b[3];
        w[FE_X] = b[2];
        w[FE_TRIM] = b[1];
        w[FE_SUPPLY] = b[0];
        feWord = w;
    endfunction

    // System bank bits placed into the 16-bit word
    function automatic logic [15:0] sfWord(input logic [SF_FLAGS-1:0] b);
        logic [15:0] w;
        w = 16'h0000;
        w[SF_CRC] = b[5];
        w[SF_FRAME] = b[4];
        w[SF_THX_LO +: 4] = b[3:0];
        sfWord = w;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************

    typedef struct packed {
        logic ready;
        logic [FRESH_W-1:0] fresh;
        logic [SET_COUNT_W-1:0] setCount;
        logic [1:0] alert;
        logic [15:0] rdData;
        logic rdValid;
        logic wrRefused;
    } csrr_state_t;

    csrr_state_t state;
    csrr_state_t next_state;

    logic [FE_FLAGS-1:0] feFlags;
    logic [SF_FLAGS-1:0] sfFlags;
    logic [FE_FLAGS-1:0] feSet;
    logic [SF_FLAGS-1:0] sfSet;
    logic feReadClear;
    logic sfReadClear;
    logic [RESULT_CNT-1:0] resultLoad;
    logic [15:0] resultWord;
    logic [15:0] convWord;

    // ****************************************************************
    // Event gathering
    // ****************************************************************

    // Diagnostic events latch into the front-end bank; power-up only by reset
    assign feSet = {
        1'b0,
        sensorDiagFail,
        tempDiagFail,
        zElementDiagFail, yElementDiagFail, xElementDiagFail,
        trimDataError,
        internalSupplyFault
    };

    // System flag events
    assign sfSet = {crcError, frameError, thresholdCross};

    // A read of the owning word clears its flags; the read returns the old value
    assign feReadClear = rdReq && (rdAddr == OFF_FRONT_END);
    assign sfReadClear = rdReq && (rdAddr == OFF_SYS_FLAGS);

    // Results load only for channels marked fresh in the finished set
    assign resultLoad = {RESULT_CNT{convDone}} & convFresh[3:0];

    // ****************************************************************
    // Submodules
    // ****************************************************************

    // Front-end diagnostics flags, power-up flag set at reset
    csrr_sticky_flags #(
        .N(FE_FLAGS),
        .RESET_VAL(RST_FE_BANK)
    ) u_fe_flags (
        .clk(clk),
        .sys_rst(sys_rst),
        .setIn(feSet),
        .readClear(feReadClear),
        .flags(feFlags)
    );

    // System flag word
    csrr_sticky_flags #(
        .N(SF_FLAGS),
        .RESET_VAL(RST_SF_BANK)
    ) u_sf_flags (
        .clk(clk),
        .sys_rst(sys_rst),
        .setIn(sfSet),
        .readClear(sfReadClear),
        .flags(sfFlags)
    );

    // Result words, read only from the register port
    csrr_result_bank u_results (
        .clk(clk),
        .sys_rst(sys_rst),
        .loadEn(resultLoad),
        .xIn(xResult),
        .yIn(yResult),
        .zIn(zResult),
        .tIn(tempResult),
        .rdIdx(resultIdx(rdAddr)),
        .rdWord(resultWord)
    );

    // ****************************************************************
    // Conversion state word assembly
    // ****************************************************************

    // Fields packed into their bit positions; reserved bits stay zero
    always_comb begin
        convWord = RST_CONV_STATE;
        convWord[CS_READY] = state.ready;
        convWord[CS_ANGLE] = state.fresh[4];
        convWord[CS_TEMP] = state.fresh[3];
        convWord[CS_Z] = state.fresh[2];
        convWord[CS_Y] = state.fresh[1];
        convWord[CS_X] = state.fresh[0];
        convWord[CS_COUNT_LO +: SET_COUNT_W] = state.setCount;
        convWord[CS_ALERT_LO +: 2] = state.alert;
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    // Conversion tracking, alert summary and register port answers
    always_comb begin
        next_state = state;

        // A new set invalidates the buffer until it completes
        if (convStart) begin
            next_state.ready = 1'b0;
            next_state.fresh = '0;
        end

        // Completion wins over a start in the same cycle
        if (convDone) begin
            next_state.ready = 1'b1;
            next_state.fresh = convFresh;
            next_state.setCount = state.setCount + SET_COUNT_ONE;
        end

        // Summary follows the flag banks one cycle later
        unique case ({|sfFlags, |feFlags})
            2'b00: next_state.alert = ALERT_NONE;
            2'b01: next_state.alert = ALERT_FE;
            2'b10: next_state.alert = ALERT_SYS;
            2'b11: next_state.alert = ALERT_BOTH;
        endcase

        // Read answer one cycle after the request; unmapped reads give zero
        next_state.rdValid = rdReq;
        next_state.rdData = 16'h0000;
        if (rdReq) begin
            if (rdAddr == OFF_CONV_STATE) begin
                next_state.rdData = convWord;
            end else if (isResult(rdAddr)) begin
                next_state.rdData = resultWord;
            end else if (rdAddr == OFF_FRONT_END) begin
                next_state.rdData = feWord(feFlags);
            end else if (rdAddr == OFF_SYS_FLAGS) begin
                next_state.rdData = sfWord(sfFlags);
            end
        end

        // Every word here is read-only, so writes are dropped and flagged
        next_state.wrRefused = wrReq && isMapped(wrAddr);
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Reset values match the documented register resets
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state.ready <= 1'b0;
            state.fresh <= '0;
            state.setCount <= '0;
            state.alert <= ALERT_NONE;
            state.rdData <= 16'h0000;
            state.rdValid <= 1'b0;
            state.wrRefused <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // All outputs come straight from the state register
    assign rdData = state.rdData;
    assign rdValid = state.rdValid;
    assign wrRefused = state.wrRefused;
    assign convReady = state.ready;
    assign alertSummary = state.alert;

endmodule

/* File: common/csrr_pkg.sv */
// ****************************************************************
// Register map and field layout
// ****************************************************************
package csrr_pkg;

    // Register offsets (word index on the register port)
    localparam logic [3:0] OFF_CONV_STATE = 4'h8;
    localparam logic [3:0] OFF_X_RESULT = 4'h9;
    localparam logic [3:0] OFF_Y_RESULT = 4'hA;
    localparam logic [3:0] OFF_Z_RESULT = 4'hB;
    localparam logic [3:0] OFF_THERMAL = 4'hC;
    localparam logic [3:0] OFF_FRONT_END = 4'hD;
    localparam logic [3:0] OFF_SYS_FLAGS = 4'hE;

    // Reset values
    localparam logic [15:0] RST_CONV_STATE = 16'h0000;
    localparam logic [15:0] RST_RESULT = 16'h0000;
    localparam logic [15:0] RST_FRONT_END = 16'h8000;
    localparam logic [15:0] RST_SYS_FLAGS = 16'h0000;

    // Conversion state word fields
    localparam int CS_READY = 13;
    localparam int CS_ANGLE = 12;
    localparam int CS_TEMP = 11;
    localparam int CS_Z = 10;
    localparam int CS_Y = 9;
    localparam int CS_X = 8;
    localparam int CS_COUNT_LO = 4;
    localparam int CS_ALERT_LO = 0;

    // Front-end diagnostics fields
    localparam int FE_POWER_UP = 15;
    localparam int FE_SENSOR = 12;
    localparam int FE_TEMP = 11;
    localparam int FE_Z = 10;
    localparam int FE_Y = 9;
    localparam int FE_X = 8;
    localparam int FE_TRIM = 1;
    localparam int FE_SUPPLY = 0;

    // System flag word fields
    localparam int SF_CRC = 12;
    localparam int SF_FRAME = 11;
    localparam int SF_THX_LO = 0;

    // Sticky flag bank widths and reset patterns (power-up flag is bank bit 7)
    localparam int FE_FLAGS = 8;
    localparam int SF_FLAGS = 6;
    localparam logic [FE_FLAGS-1:0] RST_FE_BANK = 8'h80;
    localparam logic [SF_FLAGS-1:0] RST_SF_BANK = 6'h00;

    // Fresh vector order: {angle, temp, z, y, x}
    localparam int FRESH_W = 5;
    localparam int RESULT_CNT = 4;
    localparam int SET_COUNT_W = 3;
    localparam logic [SET_COUNT_W-1:0] SET_COUNT_ONE = 3'h1;

    // Alert summary encodings
    localparam logic [1:0] ALERT_NONE = 2'h0;
    localparam logic [1:0] ALERT_FE = 2'h1;
    localparam logic [1:0] ALERT_SYS = 2'h2;
    localparam logic [1:0] ALERT_BOTH = 2'h3;

endpackage

/* File: hdl/csrr_sticky_flags.sv */
`timescale 1ns/1ps
// ****************************************************************
// Sticky read-clear flag bank
// ****************************************************************
module csrr_sticky_flags #(
    parameter int N = 8,
    parameter logic [N-1:0] RESET_VAL = '0
) (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic [N-1:0] setIn, // Event per flag
    input wire logic readClear, // Owning word read this cycle
    output logic [N-1:0] flags // Current flag values
);

    typedef struct packed {
        logic [N-1:0] flags;
    } csrr_flag_state_t;

    csrr_flag_state_t state;
    csrr_flag_state_t next_state;

    // Set wins over a read clear in the same cycle so no event is lost
    always_comb begin
        next_state = state;
        if (readClear) begin
            next_state.flags = '0;
        end
        next_state.flags = next_state.flags | setIn;
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state.flags <= RESET_VAL;
        end else begin
            state <= next_state;
        end
    end

    assign flags = state.flags;

endmodule

/* File: hdl/csrr_result_bank.sv */
`timescale 1ns/1ps
// ****************************************************************
// Conversion result storage, indexed X, Y, Z, temperature
// ****************************************************************
module csrr_result_bank
    import csrr_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic [RESULT_CNT-1:0] loadEn, // Per-word load strobe
    input wire logic [15:0] xIn, // X field result
    input wire logic [15:0] yIn, // Y field result
    input wire logic [15:0] zIn, // Z field result
    input wire logic [15:0] tIn, // Temperature result
    input wire logic [1:0] rdIdx, // Read index
    output logic [15:0] rdWord // Selected word
);

    typedef struct packed {
        logic [RESULT_CNT-1:0][15:0] word;
    } csrr_bank_state_t;

    csrr_bank_state_t state;
    csrr_bank_state_t next_state;
    logic [RESULT_CNT-1:0][15:0] inWord;

    assign inWord = {tIn, zIn, yIn, xIn};

    // Only channels fresh in this set load; others keep the older value
    always_comb begin
        next_state = state;
        for (int i = 0; i < RESULT_CNT; i++) begin
            if (loadEn[i]) begin
                next_state.word[i] = inWord[i];
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state.word <= {RESULT_CNT{RST_RESULT}};
        end else begin
            state <= next_state;
        end
    end

    assign rdWord = state.word[rdIdx];

endmodule

/* File: tb/csrr_checker.sv */
`timescale 1ns/1ps
// ****************************************************************
// Port checks for the status register block
// ****************************************************************
module csrr_checker
    import csrr_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic sys_rst, // Sync reset
    input wire logic rdReq, // Read request
    input wire logic [3:0] rdAddr, // Read offset
    input wire logic wrReq, // Write request
    input wire logic [3:0] wrAddr, // Write offset
    input wire logic [15:0] rdData, // Read data
    input wire logic rdValid, // Read answer
    input wire logic wrRefused, // Write ignored
    input wire logic convStart, // Set begins
    input wire logic convDone, // Set complete
    input wire logic sensorDiagFail, // Diag event
    input wire logic tempDiagFail, // Diag event
    input wire logic zElementDiagFail, // Diag event
    input wire logic yElementDiagFail, // Diag event
    input wire logic xElementDiagFail, // Diag event
    input wire logic trimDataError, // Diag event
    input wire logic internalSupplyFault, // Diag event
    input wire logic frameError, // System event
    input wire logic crcError, // System event
    input wire logic [3:0] thresholdCross, // System events
    input wire logic convReady, // Ready copy
    input wire logic [1:0] alertSummary // Alert copy
);
    logic feEvent;
    logic sysEvent;
    logic rdMapped;
    logic wrMapped;

    // Event and decode helpers
    assign feEvent = sensorDiagFail | tempDiagFail | zElementDiagFail | yElementDiagFail
        | xElementDiagFail | trimDataError | internalSupplyFault;
    assign sysEvent = frameError | crcError | (|thresholdCross);
    assign rdMapped = (rdAddr >= OFF_CONV_STATE) && (rdAddr <= OFF_SYS_FLAGS);
    assign wrMapped = (wrAddr >= OFF_CONV_STATE) && (wrAddr <= OFF_SYS_FLAGS);

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // Event latched, and no clearing read of the owning word on the next edge
    sequence s_fe_alert;
        feEvent ##1 !(rdReq && rdAddr == OFF_FRONT_END);
    endsequence
    sequence s_sys_alert;
        sysEvent ##1 !(rdReq && rdAddr == OFF_SYS_FLAGS);
    endsequence

    property p_rd_answer;
        rdReq |=> rdValid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_idle;
        !rdValid |-> rdData == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("data outside answer");
    property p_unmapped;
        rdReq && !rdMapped |=> rdData == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_conv_copy;
        rdReq && rdAddr == OFF_CONV_STATE |=> rdData[CS_READY] == $past(convReady)
            && rdData[1:0] == $past(alertSummary) && rdData[15:14] == 2'h0 && !rdData[7] && rdData[3:2] == 2'h0;
    endproperty
    a_conv_copy: assert property (p_conv_copy) else $error("state word mismatch");
    property p_wr_refuse;
        wrReq && wrMapped |=> wrRefused;
    endproperty
    a_wr_refuse: assert property (p_wr_refuse) else $error("write not refused");
    property p_wr_quiet;
        !(wrReq && wrMapped) |=> !wrRefused;
    endproperty
    a_wr_quiet: assert property (p_wr_quiet) else $error("spurious refusal");
    property p_ready_set;
        convDone |=> convReady;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready not set");
    property p_ready_clr;
        convStart && !convDone |=> !convReady;
    endproperty
    a_ready_clr: assert property (p_ready_clr) else $error("ready not cleared");
    property p_ready_hold;
        !convStart && !convDone |=> $stable(convReady);
    endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("ready moved");
    property p_fe_alert;
        s_fe_alert |=> alertSummary[0];
    endproperty
    a_fe_alert: assert property (p_fe_alert) else $error("front-end alert missing");
    property p_sys_alert;
        s_sys_alert |=> alertSummary[1];
    endproperty
    a_sys_alert: assert property (p_sys_alert) else $error("system alert missing");
endmodule

/* File: tb/csrr_host_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Host controller model on the register port
// ****************************************************************
module csrr_host_model (
    input wire logic clk, // System clock
    input wire logic [15:0] rdData, // Read data
    input wire logic rdValid, // Read answer
    input wire logic wrRefused, // Write ignored
    output logic rdReq, // Read request
    output logic [3:0] rdAddr, // Read offset
    output logic wrReq, // Write request
    output logic [3:0] wrAddr // Write offset
);
    // Idle port at time zero
    initial begin
        rdReq = 1'b0;
        rdAddr = 4'h0;
        wrReq = 1'b0;
        wrAddr = 4'h0;
    end

    // One read, answer taken at the edge after the request; a read of the
    // front-end word doubles as the reset acknowledge
    task automatic read_word(input logic [3:0] a, output logic [15:0] d, output logic ok);
        rdReq = 1'b1;
        rdAddr = a;
        @(posedge clk);
        #1;
        ok = rdValid;
        d = rdData;
        rdReq = 1'b0;
        rdAddr = ~a; // Released address never repeats the last offset
        @(posedge clk);
        #1;
    endtask

    // One write, no data lines exist
    task automatic write_word(input logic [3:0] a, output logic refused);
        wrReq = 1'b1;
        wrAddr = a;
        @(posedge clk);
        #1;
        refused = wrRefused;
        wrReq = 1'b0;
        wrAddr = ~a;
        @(posedge clk);
        #1;
    endtask
endmodule

/* File: tb/csrr_status_regs_bench.sv */
`timescale 1ns/1ps
// ****************************************************************
// Bench for the status and result register block
// ****************************************************************
module csrr_status_regs_bench
    import csrr_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic convStart = 1'b0;
    logic convDone = 1'b0;
    logic [4:0] convFresh = 5'h00;
    logic [15:0] xR = 16'h0000;
    logic [15:0] yR = 16'h0000;
    logic [6:0] feEv = 7'h00;
    logic frameError = 1'b0;
    logic crcError = 1'b0;
    logic [3:0] thresholdCross = 4'h0;
    logic rdReq, wrReq, rdValid, wrRefused, convReady;
    logic [3:0] rdAddr, wrAddr;
    logic [15:0] rdData;
    logic [1:0] alertSummary;
    int bad_count = 0;
    int n_checks = 0;
    int feBit[7] = '{12, 11, 10, 9, 8, 1, 0};

    // Clock at 125 MHz
    always #4 clk = ~clk;

    csrr_status_regs csrr_status_regs_inst (.clk(clk), .sys_rst(sys_rst), .rdReq(rdReq), .rdAddr(rdAddr),
        .wrReq(wrReq), .wrAddr(wrAddr), .rdData(rdData), .rdValid(rdValid), .wrRefused(wrRefused),
        .convStart(convStart), .convDone(convDone), .convFresh(convFresh), .xResult(xR), .yResult(yR),
        .zResult(~xR), .tempResult(~yR), .sensorDiagFail(feEv[6]), .tempDiagFail(feEv[5]),
        .zElementDiagFail(feEv[4]), .yElementDiagFail(feEv[3]), .xElementDiagFail(feEv[2]),
        .trimDataError(feEv[1]), .internalSupplyFault(feEv[0]), .frameError(frameError),
        .crcError(crcError), .thresholdCross(thresholdCross), .convReady(convReady), .alertSummary(alertSummary));

    csrr_host_model csrr_host_model_inst (.clk(clk), .rdData(rdData), .rdValid(rdValid), .wrRefused(wrRefused),
        .rdReq(rdReq), .rdAddr(rdAddr), .wrReq(wrReq), .wrAddr(wrAddr));

    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    // Read a word and compare, a missing answer counts as a mismatch
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        csrr_host_model_inst.read_word(a, d, ok);
        check("answer", {15'h0000, ok}, 16'h0001);
        check($sformatf("word %h", a), d, exp);
    endtask

    // Reset image of every word, whose front-end read is the acknowledge, then a check that it cleared
    task automatic t_reset();
        check("alert", {14'h0000, alertSummary}, {14'h0000, ALERT_FE});
        for (int a = 3; a <= 14; a++) begin
            if (a < 4 || a > 7) begin
                // Power-up flag is a front-end flag, so the state word shows it in its alert field
                rd_chk(a[3:0], (a == 13) ? RST_FRONT_END : (a == 8) ? {14'h0000, ALERT_FE} : RST_RESULT);
            end
        end
        rd_chk(OFF_FRONT_END, 16'h0000);
        check("alert", {14'h0000, alertSummary}, {14'h0000, ALERT_NONE});
    endtask

    // Full set, then a partial set, then the count wrap
    task automatic t_conv();
        convDone = 1'b1;
        convFresh = 5'h1F;
        xR = 16'h1234;
        yR = 16'hA5C3;
        tick();
        convDone = 1'b0;
        tick();
        check("ready", {15'h0000, convReady}, 16'h0001);
        rd_chk(OFF_CONV_STATE, 16'h3F10);
        rd_chk(OFF_X_RESULT, 16'h1234);
        rd_chk(OFF_Y_RESULT, 16'hA5C3);
        rd_chk(OFF_Z_RESULT, 16'hEDCB);
        rd_chk(OFF_THERMAL, 16'h5A3C);
        convStart = 1'b1;
        tick();
        convStart = 1'b0;
        rd_chk(OFF_CONV_STATE, 16'h0010);
        convDone = 1'b1;
        convFresh = 5'h05;
        xR = 16'h0F0F;
        yR = 16'h7777;
        tick();
        convFresh = 5'h00;
        repeat (6) tick();
        convDone = 1'b0;
        rd_chk(OFF_X_RESULT, 16'h0F0F);
        rd_chk(OFF_Y_RESULT, 16'hA5C3);
        rd_chk(OFF_Z_RESULT, 16'hF0F0);
        rd_chk(OFF_THERMAL, 16'h5A3C);
        rd_chk(OFF_CONV_STATE, 16'h2000);
    endtask

    // Each front-end fault alone: latch, alert, clear on read
    task automatic t_diag();
        for (int i = 0; i < 7; i++) begin
            feEv = 7'h40 >> i;
            tick();
            feEv = 7'h00;
            tick();
            check("alert", {14'h0000, alertSummary}, {14'h0000, ALERT_FE});
            rd_chk(OFF_FRONT_END, 16'h0001 << feBit[i]);
            rd_chk(OFF_FRONT_END, 16'h0000);
        end
    endtask

    // System flags alone and together with a front-end flag
    task automatic t_sys();
        frameError = 1'b1;
        feEv = 7'h01;
        tick();
        frameError = 1'b0;
        feEv = 7'h00;
        tick();
        check("alert", {14'h0000, alertSummary}, {14'h0000, ALERT_BOTH});
        rd_chk(OFF_SYS_FLAGS, 16'h0800);
        check("alert", {14'h0000, alertSummary}, {14'h0000, ALERT_FE});
        rd_chk(OFF_FRONT_END, 16'h0001);
        crcError = 1'b1;
        thresholdCross = 4'hF;
        tick();
        crcError = 1'b0;
        thresholdCross = 4'h0;
        tick();
        check("alert", {14'h0000, alertSummary}, {14'h0000, ALERT_SYS});
        rd_chk(OFF_SYS_FLAGS, 16'h100F);
        rd_chk(OFF_SYS_FLAGS, 16'h0000);
    endtask

    // Writes are refused on mapped words and change nothing
    task automatic t_write();
        logic r;
        csrr_host_model_inst.write_word(OFF_X_RESULT, r);
        check("refused", {15'h0000, r}, 16'h0001);
        csrr_host_model_inst.write_word(4'h3, r);
        check("unmapped refusal", {15'h0000, r}, 16'h0000);
        rd_chk(OFF_X_RESULT, 16'h0F0F);
    endtask

    task automatic print_verdict();
        if (bad_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence after a 16-cycle reset
    initial begin
        repeat (16) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        tick();
        t_reset();
        t_conv();
        t_diag();
        t_sys();
        t_write();
        print_verdict();
    end

    // Hang guard
    initial begin
        #100000;
        bad_count++;
        print_verdict();
    end
endmodule

bind csrr_status_regs csrr_checker csrr_checker_inst (.clk(clk), .sys_rst(sys_rst), .rdReq(rdReq),
    .rdAddr(rdAddr), .wrReq(wrReq), .wrAddr(wrAddr), .rdData(rdData), .rdValid(rdValid),
    .wrRefused(wrRefused), .convStart(convStart), .convDone(convDone), .sensorDiagFail(sensorDiagFail),
    .tempDiagFail(tempDiagFail), .zElementDiagFail(zElementDiagFail), .yElementDiagFail(yElementDiagFail),
    .xElementDiagFail(xElementDiagFail), .trimDataError(trimDataError), .internalSupplyFault(internalSupplyFault),
    .frameError(frameError), .crcError(crcError), .thresholdCross(thresholdCross), .convReady(convReady),
    .alertSummary(alertSummary));
